/* crm_clock_reset_map.svh */
`ifndef CRM_CLOCK_RESET_MAP_SVH
`define CRM_CLOCK_RESET_MAP_SVH

// apb byte offsets
`define CRM_OFS_MAIN_CLOCK_CONTROL    12'h000
`define CRM_OFS_RC_OSCILLATOR_TRIM    12'h004
`define CRM_OFS_SUPPLY_INTEGRITY_STAT 12'h008

// main_clock_control fields
`define CRM_MCC_SLOW_BIT     0
`define CRM_MCC_CLKOUT_BIT   1
`define CRM_MCC_USED_MASK    8'h03
`define CRM_MCC_RESET        8'h00

// rc_oscillator_trim
`define CRM_TRIM_RESET       8'hff

// supply_integrity_status fields
`define CRM_SIS_LOCKED_BIT   3

// timing
`define CRM_DELAY_SHORT      13'h0100
`define CRM_DELAY_LONG       13'h1000
`define CRM_FETCH_CYCLES     2'h2
`define CRM_SLOW_DIV_LAST    5'h1f
`define CRM_CLK_PERIOD_PS    5000
`define CRM_PLL_START_NS     1000
`define CRM_WDG_ACTIVE_CYC   8'h10

`endif

/* crm_pkg.sv */
package crm_pkg;

   // main oscillator type chosen by option bits
   typedef enum logic [1:0] {
      CRM_SRC_EXT_CLOCK = 2'b00,
      CRM_SRC_CRYSTAL   = 2'b01,
      CRM_SRC_CERAMIC   = 2'b10,
      CRM_SRC_RC        = 2'b11
   } crm_clk_src_t;

   // oscillator clock mux selection
   typedef enum logic [1:0] {
      CRM_OSC_EXT  = 2'b00,
      CRM_OSC_XTAL = 2'b01,
      CRM_OSC_RC   = 2'b10,
      CRM_OSC_PLL  = 2'b11
   } crm_osc_sel_t;

   typedef enum logic [2:0] {
      CRM_ST_RUN    = 3'b000,
      CRM_ST_ACTIVE = 3'b001,
      CRM_ST_DELAY  = 3'b010,
      CRM_ST_PLL    = 3'b011,
      CRM_ST_FETCH  = 3'b100
   } crm_state_t;

   // option byte settings
   typedef struct packed {
      crm_clk_src_t clk_src;
      logic         pll_en;
      logic         pll_x8;
      logic         ccm_en;
      logic         ccm_halve;
   } crm_opt_t;

   // reset sources, active high
   typedef struct packed {
      logic low_voltage_detector;
      logic wdg;
   } crm_rst_src_t;

endpackage : crm_pkg

/* crm_clock_reset.sv */
// Summary of operation
// R01: every reset returns rc_oscillator_trim to ffh.
// R02: trim value zero gives fastest rc clock, ffh slowest.
// R03: software reloads trim after each reset from factory bytes.
// R04: option bits enable the pll and pick multiply by 4 or 8.
// R05: pll off with rc on gives the plain 1 mhz rc clock.
// R06: rc and pll both off take the external clock directly.
// R07: after reset or halt wakeup the pll output waits its start delay.
// R08: pll lock flag is set once the pll output is running.
// R09: main_clock_control bit 1 drives the main clock out; reset clears.
// R10: main_clock_control bit 0 selects cpu clock divided by 32; reset clears.
// R11: software keeps main_clock_control bits 7:2 zero.
// R12: counter clock multiplier takes 8 mhz, from rc x8 or halved 16 mhz.
// R13: lvd, watchdog and pin sources; reset pin held low during delay.
// R14: reset runs active phase, stabilisation delay, then vector fetch.
// R15: delay is 256 cycles for rc or external clock, 4096 for crystal.
// R16: vector fetch lasts two cycles.
// R17: enabled pll adds its start delay before the clock is released.
// R18: a low reset pin is seen even while the device is halted.
// R19: reset pin is open drain; outside may pull it low.
// R20: crystal oscillators keep running during reset.
// R21: option picks external, crystal, ceramic or rc main clock.
// R22: lock flag is bit 3 of supply_integrity_status, hardware only.
`timescale 1ns/1ps
`default_nettype none
`include "crm_clock_reset_map.svh"

module crm_clock_reset
   import crm_pkg::*;
#(
   parameter int PLL_START_NS  = `CRM_PLL_START_NS,
   parameter int PLL_START_CYC = (PLL_START_NS * 1000) / `CRM_CLK_PERIOD_PS,
   parameter int PLL_CNT_W     = 16
)(
   input  wire logic         i_core_clk,
   input  wire logic         i_srst,
   input  wire logic         i_clk_en,
   input  wire logic         i_psel,
   input  wire logic         i_penable,
   input  wire logic         i_pwrite,
   input  wire logic [11:0]  i_paddr,
   input  wire logic [31:0]  i_pwdata,
   input  wire logic [3:0]   i_pstrb,
   output logic [31:0]       o_prdata,
   output logic              o_pready,
   output logic              o_pslverr,
   input  wire crm_opt_t     i_opt,
   input  wire crm_rst_src_t i_rst_src,
   input  wire logic         i_rst_pin_n_in,
   output logic              o_rst_pin_out,
   output logic              o_rst_pin_oe_n,
   input  wire logic         i_halt,
   output logic              o_cpu_rst,
   output logic              o_vector_fetch,
   output logic              o_cpu_clk_en,
   output crm_osc_sel_t      o_osc_sel,
   output logic              o_pll_run,
   output logic              o_pll_x8,
   output logic              o_pll_clk_gate,
   output logic              o_xtal_run,
   output logic [7:0]        o_rc_trim_value,
   output logic              o_clock_output_enable,
   output logic              o_ccm_en,
   output logic              o_ccm_halve
);

   function automatic logic is_crystal(input crm_clk_src_t src);
      is_crystal = (src == CRM_SRC_CRYSTAL) || (src == CRM_SRC_CERAMIC);
   endfunction : is_crystal

   crm_state_t             state_q;
   crm_state_t             state_d;
   logic [12:0]            delay_cnt_q;
   logic [7:0]             active_cnt_q;
   logic [1:0]             fetch_cnt_q;
   logic [PLL_CNT_W-1:0]   pll_cnt_q;
   logic                   pll_ready_q;
   logic                   pin_low_q;
   logic                   halt_q;
   logic [4:0]             div_q;
   logic [7:0]             main_clock_control_q;
   logic [7:0]             rc_trim_value_q;

   // apb decode
   wire logic        apb_setup  = i_psel & ~i_penable;
   wire logic        apb_access = i_psel & i_penable;
   wire logic        hit_mcc    = i_paddr == `CRM_OFS_MAIN_CLOCK_CONTROL;
   wire logic        hit_trim   = i_paddr == `CRM_OFS_RC_OSCILLATOR_TRIM;
   wire logic        hit_sis    = i_paddr == `CRM_OFS_SUPPLY_INTEGRITY_STAT;
   wire logic        hit_any    = hit_mcc | hit_trim | hit_sis;
   wire logic        in_run     = state_q == CRM_ST_RUN;
   wire logic        wr_ok      = apb_access & i_pwrite & i_pstrb[0] & in_run;
   wire logic        wr_mcc     = wr_ok & hit_mcc;
   wire logic        wr_trim    = wr_ok & hit_trim;
   wire logic [7:0]  sis_value  = {4'h0, pll_ready_q, 3'h0} &
                                  (8'h01 << `CRM_SIS_LOCKED_BIT); // R22
   wire logic [7:0]  rd_byte    = hit_mcc  ? main_clock_control_q :
                                  hit_trim ? rc_trim_value_q :
                                  hit_sis  ? sis_value : 8'h00;

   // reset sources
   wire logic        int_src    = i_rst_src.low_voltage_detector | i_rst_src.wdg; // R13
   wire logic        pin_driven = ~o_rst_pin_oe_n;
   wire logic        ext_src    = pin_low_q & ~pin_driven; // R19
   wire logic        any_src    = int_src | ext_src;
   wire logic [12:0] delay_len  = is_crystal(i_opt.clk_src) ?
                                  `CRM_DELAY_LONG : `CRM_DELAY_SHORT; // R15
   wire logic        delay_done = delay_cnt_q == delay_len - 13'h0001;
   wire logic        active_done = active_cnt_q >= `CRM_WDG_ACTIVE_CYC;
   wire logic        fetch_done = fetch_cnt_q == `CRM_FETCH_CYCLES - 2'h1; // R16
   wire logic        enter_rst  = state_d == CRM_ST_ACTIVE;
   wire logic        next_run   = state_d == CRM_ST_RUN;
   wire logic        regs_clear = i_srst | enter_rst; // R01

   // pll control
   wire logic        pll_on      = i_opt.pll_en & ~i_halt; // R04
   // pll held through the delay phase so its start time adds on
   wire logic        pll_restart = ~pll_on | (halt_q & ~i_halt) |
                                   (state_q == CRM_ST_ACTIVE) |
                                   (state_q == CRM_ST_DELAY); // R07 R17
   wire logic        pll_hit     = pll_cnt_q == PLL_CNT_W'(PLL_START_CYC - 1);

   // cpu clock divider
   wire logic        slow_mode  = main_clock_control_q[`CRM_MCC_SLOW_BIT] & in_run;
   wire logic        div_last   = div_q == `CRM_SLOW_DIV_LAST;
   wire logic        cpu_tick   = ~slow_mode | div_last; // R10

   // oscillator selection
   wire crm_osc_sel_t osc_sel_d =
      i_opt.pll_en                     ? CRM_OSC_PLL :  // R04
      (i_opt.clk_src == CRM_SRC_RC)    ? CRM_OSC_RC  :  // R05
      is_crystal(i_opt.clk_src)        ? CRM_OSC_XTAL : // R21
                                         CRM_OSC_EXT;   // R06
   wire logic ccm_src_ok = (i_opt.pll_en & i_opt.pll_x8) | i_opt.ccm_halve;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CRM_ST_RUN:
         begin
            if (any_src)
               state_d = CRM_ST_ACTIVE;
         end
         CRM_ST_ACTIVE:
         begin
            if (!any_src && (active_done || !i_rst_src.wdg))
               state_d = CRM_ST_DELAY; // R14
         end
         CRM_ST_DELAY:
         begin
            if (int_src)
               state_d = CRM_ST_ACTIVE;
            else if (delay_done && i_opt.pll_en)
               state_d = CRM_ST_PLL; // R17
            else if (delay_done)
               state_d = CRM_ST_FETCH; // R14
         end
         CRM_ST_PLL:
         begin
            if (any_src)
               state_d = CRM_ST_ACTIVE;
            else if (pll_ready_q)
               state_d = CRM_ST_FETCH; // R17
         end
         CRM_ST_FETCH:
         begin
            if (any_src)
               state_d = CRM_ST_ACTIVE;
            else if (fetch_done)
               state_d = CRM_ST_RUN; // R16
         end
         default:
            state_d = CRM_ST_ACTIVE;
      endcase
   end

   // pin sampling stays live without clock enable so halt cannot hide it
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
         pin_low_q <= 1'b0;
      // our own drive shows on the pin in the same cycle; ignore it
      else if (~i_rst_pin_n_in & o_rst_pin_oe_n)
         pin_low_q <= 1'b1; // R18 R19
      else if (i_clk_en)
         pin_low_q <= 1'b0;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
         state_q <= CRM_ST_ACTIVE;
      else if (i_clk_en || pin_low_q)
         state_q <= state_d;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         delay_cnt_q  <= 13'h0000;
         active_cnt_q <= 8'h00;
         fetch_cnt_q  <= 2'h0;
      end
      else if (i_clk_en)
      begin
         delay_cnt_q  <= (state_q == CRM_ST_DELAY && cpu_tick) ?
                         delay_cnt_q + 13'h0001 : 13'h0000; // R15
         active_cnt_q <= (state_q != CRM_ST_ACTIVE) ? 8'h00 :
                         active_done ? active_cnt_q : active_cnt_q + 8'h01;
         fetch_cnt_q  <= (state_q == CRM_ST_FETCH) ?
                         fetch_cnt_q + 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         pll_cnt_q   <= '0;
         pll_ready_q <= 1'b0;
         halt_q      <= 1'b0;
      end
      else if (i_clk_en)
      begin
         halt_q <= i_halt;
         if (pll_restart)
         begin
            pll_cnt_q   <= '0;
            pll_ready_q <= 1'b0; // R07
         end
         else if (pll_hit)
            pll_ready_q <= 1'b1; // R08
         else if (!pll_ready_q)
            pll_cnt_q <= pll_cnt_q + PLL_CNT_W'(1);
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
         div_q <= 5'h00;
      else if (i_clk_en)
         div_q <= slow_mode ? div_q + 5'h01 : 5'h00;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (regs_clear)
      begin
         main_clock_control_q <= `CRM_MCC_RESET; // R09 R10
         rc_trim_value_q      <= `CRM_TRIM_RESET; // R01
      end
      else if (i_clk_en)
      begin
         if (wr_mcc)
            main_clock_control_q <= i_pwdata[7:0] & `CRM_MCC_USED_MASK; // R11
         if (wr_trim)
            rc_trim_value_q <= i_pwdata[7:0]; // R03
      end
   end

   // zero-wait apb: answer prepared in setup, shown in access
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_pready  <= apb_setup;
         o_pslverr <= apb_setup & ~hit_any;
         o_prdata  <= (apb_setup & ~i_pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_rst_pin_out   <= 1'b0;
         o_rst_pin_oe_n  <= 1'b1;
         o_cpu_rst       <= 1'b1;
         o_vector_fetch  <= 1'b0;
         o_cpu_clk_en    <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_rst_pin_out  <= 1'b0;
         o_rst_pin_oe_n <= ~((state_d == CRM_ST_DELAY) ||
                             (state_d == CRM_ST_ACTIVE && int_src)); // R13
         o_cpu_rst      <= (state_d != CRM_ST_RUN) && (state_d != CRM_ST_FETCH);
         o_vector_fetch <= state_d == CRM_ST_FETCH; // R16
         o_cpu_clk_en   <= cpu_tick & next_run;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_osc_sel             <= CRM_OSC_EXT;
         o_pll_run             <= 1'b0;
         o_pll_x8              <= 1'b0;
         o_pll_clk_gate        <= 1'b0;
         o_xtal_run            <= 1'b0;
         o_rc_trim_value       <= `CRM_TRIM_RESET;
         o_clock_output_enable <= 1'b0;
         o_ccm_en              <= 1'b0;
         o_ccm_halve           <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_osc_sel             <= osc_sel_d; // R21
         o_pll_run             <= pll_on;
         o_pll_x8              <= i_opt.pll_x8; // R04
         o_pll_clk_gate        <= pll_ready_q & ~pll_restart; // R07 R17
         o_xtal_run            <= is_crystal(i_opt.clk_src); // R20
         o_rc_trim_value       <= enter_rst ? `CRM_TRIM_RESET : rc_trim_value_q; // R01 R02
         o_clock_output_enable <= main_clock_control_q[`CRM_MCC_CLKOUT_BIT] &
                                  next_run; // R09
         o_ccm_en              <= i_opt.ccm_en & ccm_src_ok; // R12
         o_ccm_halve           <= i_opt.ccm_halve; // R12
      end
   end

endmodule : crm_clock_reset
`default_nettype wire

/* crm_clock_reset_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module crm_clock_reset_assertions
   import crm_pkg::*;
#(
   parameter int PLL_START_CYC = 8
)(
   input wire logic         i_core_clk,
   input wire logic         i_srst,
   input wire logic         i_halt,
   input wire crm_opt_t     i_opt,
   input wire logic         o_rst_pin_out,
   input wire logic         o_rst_pin_oe_n,
   input wire logic         o_cpu_rst,
   input wire logic         o_vector_fetch,
   input wire logic         o_cpu_clk_en,
   input wire crm_osc_sel_t o_osc_sel,
   input wire logic         o_pll_run,
   input wire logic         o_pll_x8,
   input wire logic         o_pll_clk_gate,
   input wire logic         o_xtal_run,
   input wire logic [7:0]   o_rc_trim_value,
   input wire logic         o_clock_output_enable
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   logic [15:0]  low_q;
   logic [15:0]  low_d;
   wire logic    long_dly;
   crm_osc_sel_t exp_sel;
   // length of the current pin-low stretch, saturating
   assign low_d = o_rst_pin_oe_n ? 16'h0000 : (&low_q ? low_q : low_q + 16'h0001);
   assign long_dly = (i_opt.clk_src == CRM_SRC_CRYSTAL) || (i_opt.clk_src == CRM_SRC_CERAMIC);
   assign exp_sel = i_opt.pll_en ? CRM_OSC_PLL : (i_opt.clk_src == CRM_SRC_RC) ? CRM_OSC_RC :
                    (i_opt.clk_src == CRM_SRC_EXT_CLOCK) ? CRM_OSC_EXT : CRM_OSC_XTAL;
   always_ff @(posedge i_core_clk)
      low_q <= i_srst ? 16'h0000 : low_d;
   a_delay_length: assert property (
      $rose(o_rst_pin_oe_n) |-> low_q >= (long_dly ? 16'h1000 : 16'h0100))
      else $error("reset pin released before the stabilisation delay");
   a_fetch_two: assert property (
      $rose(o_vector_fetch) |-> o_vector_fetch [*2] ##1 !o_vector_fetch)
      else $error("vector fetch not two cycles long");
   a_fetch_after_delay: assert property (
      $rose(o_vector_fetch) && !i_opt.pll_en |-> $past(!o_rst_pin_oe_n))
      else $error("vector fetch does not follow the delay phase");
   a_pll_wait: assert property (
      $rose(o_vector_fetch) && i_opt.pll_en |-> $past(o_rst_pin_oe_n, PLL_START_CYC - 1))
      else $error("pll start delay skipped");
   a_no_tick_rst: assert property (
      o_cpu_rst |-> !o_cpu_clk_en)
      else $error("cpu ticks while held in reset");
   a_pin_drive_low: assert property (
      !o_rst_pin_out)
      else $error("reset pin driven high");
   a_regs_in_rst: assert property (
      o_cpu_rst |-> o_rc_trim_value == 8'hff && !o_clock_output_enable)
      else $error("registers not at reset value during reset");
   a_osc_mux: assert property (
      !o_cpu_rst && o_pll_clk_gate == i_opt.pll_en |-> o_osc_sel == exp_sel)
      else $error("oscillator selection wrong");
   a_pll_factor: assert property (
      o_pll_run |-> i_opt.pll_en && o_pll_x8 == i_opt.pll_x8)
      else $error("pll runs with wrong setting");
   a_xtal_kept: assert property (
      !$past(i_srst) && long_dly |-> o_xtal_run)
      else $error("crystal oscillator stopped");
endmodule : crm_clock_reset_assertions
bind crm_clock_reset crm_clock_reset_assertions #(.PLL_START_CYC(PLL_START_CYC)) chk_u (
   .i_core_clk, .i_srst, .i_halt, .i_opt, .o_rst_pin_out, .o_rst_pin_oe_n, .o_cpu_rst,
   .o_vector_fetch, .o_cpu_clk_en, .o_osc_sel, .o_pll_run, .o_pll_x8, .o_pll_clk_gate,
   .o_xtal_run, .o_rc_trim_value, .o_clock_output_enable);
`default_nettype wire

/* crm_reset_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module crm_reset_partner
(
   input wire logic  i_oe_n,
   input wire logic  i_out,
   input wire logic  i_ext_pull,
   output logic      o_pin_n
);
   // weak pull-up unless either side pulls down
   assign o_pin_n = (i_oe_n ? 1'b1 : i_out) & ~i_ext_pull;
endmodule : crm_reset_partner
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import crm_pkg::*;
;
   typedef struct {crm_opt_t o; int d; crm_osc_sel_t s;} crm_row_t;
   logic         clk, srst, ce, psel, pen, pwr, halt, pull, err, pready, pslverr;
   logic         pin_n, oe_n, pout, cpu_rst, vf, cen, coe, x8, ccm, hv;
   logic [11:0]  addr;
   logic [31:0]  wdat, rdat, prdata;
   logic [7:0]   trim;
   crm_opt_t     opt;
   crm_rst_src_t src;
   crm_osc_sel_t osel;
   int           bad_count, n_checks, cyc, n;
   crm_row_t     rows [5] = '{'{6'h01, 256, CRM_OSC_EXT}, '{6'h10, 4096, CRM_OSC_XTAL},
      '{6'h28, 4104, CRM_OSC_PLL}, '{6'h0e, 264, CRM_OSC_PLL}, '{6'h3c, 264, CRM_OSC_PLL}};

   crm_clock_reset #(.PLL_START_CYC(8)) dut_u (.i_core_clk(clk), .i_srst(srst), .i_clk_en(ce),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
      .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_opt(opt),
      .i_rst_src(src), .i_rst_pin_n_in(pin_n), .o_rst_pin_out(pout), .o_rst_pin_oe_n(oe_n),
      .i_halt(halt), .o_cpu_rst(cpu_rst), .o_vector_fetch(vf), .o_cpu_clk_en(cen),
      .o_osc_sel(osel), .o_pll_run(), .o_pll_x8(x8), .o_pll_clk_gate(), .o_xtal_run(),
      .o_rc_trim_value(trim), .o_clock_output_enable(coe), .o_ccm_en(ccm), .o_ccm_halve(hv));
   crm_reset_partner part_u (.i_oe_n(oe_n), .i_out(pout), .i_ext_pull(pull), .o_pin_n(pin_n));

   always #2.5 clk = ~clk;

   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         stop_test();
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rdat = prdata;
      err  = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("read", rdat, e);
   endtask : rd

   task wait_fetch;
      n = 0;
      while (vf !== 1'b1 && n < 9000)
      begin
         @(posedge clk);
         n++;
      end
      chk("fetch", vf, 1'b1);
   endtask : wait_fetch

   initial
   begin
      clk = 0; srst = 1; ce = 1; psel = 0; pen = 0; pwr = 0; halt = 0; pull = 0;
      addr = 0; wdat = 0; opt = 6'h00; src = 2'b00;
      foreach (rows[i])
      begin
         srst <= 1'b1;
         opt  <= rows[i].o;
         repeat (12) @(posedge clk);
         srst <= 1'b0;
         wait_fetch();
         chk("delay", n >= rows[i].d && n <= rows[i].d + 12, 1'b1);
         repeat (4) @(posedge clk);
         chk("osc", osel, rows[i].s);
         chk("pllx8", x8, rows[i].o.pll_x8);
         chk("ccm", ccm, rows[i].o.ccm_en);
         chk("halve", hv, rows[i].o.ccm_halve);
      end
      rd(12'h000, 32'h0);
      rd(12'h004, 32'hff);
      rd(12'h008, 32'h8);
      apb(1'b1, 12'h008, 32'h0);
      rd(12'h008, 32'h8);
      apb(1'b1, 12'h004, 32'h5a);
      apb(1'b1, 12'h000, 32'h3);
      rd(12'h000, 32'h3);
      chk("trim", trim, 8'h5a);
      chk("clkout", coe, 1'b1);
      n = 0;
      repeat (64) @(posedge clk) n += cen;
      chk("slow", n, 2);
      apb(1'b1, 12'h000, 32'h0);
      // skip the tick still launched at the slow rate
      @(posedge clk) n = 0;
      repeat (64) @(posedge clk) n += cen;
      chk("fast", n, 64);
      rd(12'h00c, 32'h0);
      chk("slverr", err, 1'b1);
      halt <= 1'b1;
      rd(12'h008, 32'h0);
      halt <= 1'b0;
      repeat (40) @(posedge clk);
      rd(12'h008, 32'h8);
      for (int s = 1; s < 3; s++)
      begin
         apb(1'b1, 12'h004, 32'h5a);
         @(posedge clk) src <= 2'(s);
         repeat (20) @(posedge clk);
         src <= 2'b00;
         chk("pin", pin_n, 1'b0);
         wait_fetch();
         rd(12'h004, 32'hff);
      end
      @(posedge clk) ce <= 1'b0;
      pull <= 1'b1;
      repeat (4) @(posedge clk);
      pull <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pinrst", cpu_rst, 1'b1);
      wait_fetch();
      rd(12'h000, 32'h0);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
